// file: sim_pkg.sv
// Constants shared by the microstep indexer: register offsets, fields,
// reset values and timing counts.
// Assumes a byte-wide register port driven by the surrounding device.
package sim_pkg;
	// Register addresses (byte-wide register port)
	localparam logic [7:0] ADDR_CTRL_ONE    = 8'h00;
	localparam logic [7:0] ADDR_CTRL_TWO    = 8'h01;
	localparam logic [7:0] ADDR_STALL_CFG   = 8'h02;
	localparam logic [7:0] ADDR_STALL_THR   = 8'h03;
	localparam logic [7:0] ADDR_HOLD_CFG    = 8'h04;
	localparam logic [7:0] ADDR_FAULT_STAT  = 8'h05;
	localparam logic [7:0] ADDR_SCALER_LOW  = 8'h06;
	localparam logic [7:0] ADDR_SCALER_HIGH = 8'h07;
	localparam logic [7:0] ADDR_TORQUE_CNT  = 8'h08;
	localparam logic [7:0] ADDR_POS_A       = 8'h09;
	localparam logic [7:0] ADDR_CUSTOM_BASE = 8'h10;
	localparam int         CUSTOM_ENTRIES   = 8;
	// control_word_one fields, then the resolution fields of control word two
	localparam int BIT_INDEXER_RESET_BIT     = 0;
	localparam int BIT_BOTH_EDGE   = 1;
	localparam int BIT_AUTO_EN     = 2;
	localparam int BIT_CUSTOM_EN   = 3;
	localparam int BIT_HOLD_EN     = 4;
	localparam int FLD_RES_LO      = 0;
	localparam int FLD_AUTO_RES_LO = 4;
	// Stall config fields
	localparam int BIT_STALL_EN    = 0;
	localparam int BIT_LEARN       = 1;
	localparam int BIT_KEEP_DRIVE  = 2;
	localparam int BIT_STALL_REP   = 3;
	localparam int BIT_X8          = 4;
	localparam int BIT_CLR_FLT     = 7;
	// Decay codes
	localparam logic [2:0] DECAY_RIPPLE = 3'h7;
	localparam int FLD_DECAY_LO = 5;
	// Reset values
	localparam logic [7:0] RST_CTRL_ONE  = 8'h00;
	localparam logic [7:0] RST_CTRL_TWO  = 8'he0;
	localparam logic [7:0] RST_STALL_CFG = 8'h09;
	localparam logic [7:0] RST_STALL_THR = 8'h00;
	localparam logic [7:0] RST_HOLD_CFG  = 8'h80;
	localparam logic [7:0] RST_CUSTOM    = 8'h00;
	// Indexer
	localparam logic signed [9:0] POS_MAX = 10'sh0ff;
	localparam logic [9:0] SCALE_FULL = 10'h3ff;
	// Torque sampling window
	localparam int WINDOW_NS     = 10240;
	localparam int CLK_PERIOD_NS = 10;
	localparam int WINDOW_CYC    = WINDOW_NS / CLK_PERIOD_NS;
endpackage

// file: sim_indexer.sv
// Microstep indexer with custom table, hold current and stall detection.
// Assumes step/direction arrive asynchronously from a controller pin and
// a synchronous byte register port on core_clk; torque sample from logic.
`timescale 1ns/10ps
`default_nettype none
module sim_indexer (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        clkEn,
	input  wire logic        stepPin,
	input  wire logic        dirPin,
	input  wire logic        regWr,
	input  wire logic        regRd,
	input  wire logic [7:0]  regAddr,
	input  wire logic [7:0]  regWdata,
	input  wire logic [11:0] torqueCount,
	output logic      [7:0]  regRdata,
	output logic      [9:0]  coilAMag,
	output logic      [9:0]  coilBMag,
	output logic             coilASign,
	output logic             coilBSign,
	output logic             driveEn,
	output logic             error_out_n
);
	typedef enum logic [2:0] {
		LRN_IDLE = 3'b001,
		LRN_RUN  = 3'b010,
		LRN_DONE = 3'b100
	} sim_learn_t;

	logic [7:0]  ctrlOne_ff, ctrlTwo_ff, stallCfg_ff, stallThr_ff;
	logic [7:0]  holdCfg_ff;
	logic [7:0]  custom_ff [sim_pkg::CUSTOM_ENTRIES];
	logic [2:0]  stepSync_ff;
	logic        stepPrev_ff;
	logic signed [9:0] posA_ff;
	logic [8:0]  pendSteps_ff;
	logic [15:0] idleCnt_ff;
	logic        stall_flag_ff;
	logic [11:0] learnThr_ff;
	logic [11:0] learnMax_ff;
	sim_learn_t  learn_ff;
	logic [13:0] winCnt_ff;

	////////////////////////////////////////////////////////////////////////
	// Sine table first quadrant, and a quadrant mirror shared by both coils
	function automatic logic [9:0] sinLut(input logic [7:0] i);
		logic [9:0] r;
		r = 10'h000;
		// Piecewise-linear sine approximation keeps area small
		if (i < 8'h40)
			r = 10'({i, 2'b00} + {1'b0, i, 1'b0});
		else if (i < 8'h80)
			r = 10'h0c0 + 10'({i - 8'h40, 1'b0} + {2'b00, i - 8'h40});
		else if (i < 8'hc0)
			r = 10'h180 + 10'({2'b00, i - 8'h80} + {2'b00, i - 8'h80});
		else
			r = 10'h200 + 10'({2'b00, i - 8'hc0} + {2'b00, i - 8'hc0});
		return (i == 8'hff) ? sim_pkg::SCALE_FULL : r;
	endfunction

	function automatic logic [9:0] quadMag(input logic [7:0] i,
			input logic custom, input logic [7:0] tbl [sim_pkg::CUSTOM_ENTRIES]);
		logic [2:0] seg;
		seg = i[7:5];
		if (custom)
			return {tbl[seg], tbl[seg][7:6]};
		return sinLut(i);
	endfunction

	// Signed position -> magnitude with quadrant mirroring
	function automatic logic [9:0] posMag(input logic signed [9:0] p,
			input logic custom, input logic [7:0] tbl [sim_pkg::CUSTOM_ENTRIES]);
		logic [9:0] a;
		a = p[9] ? 10'(-p) : 10'(p);
		if (a == 10'h000)
			return 10'h000;
		return quadMag(a[7:0], custom, tbl);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Step input synchroniser and edge detection
	always_ff @(posedge core_clk) begin
		if (rst) begin
			stepSync_ff <= 3'h0;
			stepPrev_ff <= 1'b0;
		end else if (clkEn) begin
			stepSync_ff <= {stepSync_ff[1:0], stepPin};
			if (stepSync_ff[2] == stepSync_ff[1])
				stepPrev_ff <= stepSync_ff[2];
		end
	end

	logic stepLvl, riseEv, fallEv, stepEv;
	assign stepLvl = (stepSync_ff[2] == stepSync_ff[1]) ? stepSync_ff[2]
		: stepPrev_ff;
	assign riseEv = stepLvl & ~stepPrev_ff;
	assign fallEv = ~stepLvl & stepPrev_ff;
	assign stepEv = riseEv | (fallEv & ctrlOne_ff[sim_pkg::BIT_BOTH_EDGE]);

	////////////////////////////////////////////////////////////////////////
	// Microsteps per input step: 256 >> resolution code, fixed at 32 in custom mode
	// Nine bits, so that a full step of 256 microsteps is kept whole
	logic [2:0] resSel;
	logic [8:0] stepSize, autoSize;
	always_comb begin
		resSel = ctrlTwo_ff[sim_pkg::FLD_RES_LO +: 3];
		stepSize = 9'h100 >> resSel;
		autoSize = 9'h100 >> ctrlTwo_ff[sim_pkg::FLD_AUTO_RES_LO +: 3];
		if (ctrlOne_ff[sim_pkg::BIT_CUSTOM_EN])
			stepSize = 9'h020;
	end

	logic autoOn;
	assign autoOn = ctrlOne_ff[sim_pkg::BIT_AUTO_EN]
		& ~ctrlOne_ff[sim_pkg::BIT_CUSTOM_EN];

	logic idxRst;
	assign idxRst = ctrlOne_ff[sim_pkg::BIT_INDEXER_RESET_BIT];

	logic doMove;
	logic [8:0] moveBy;
	always_comb begin
		doMove = 1'b0;
		moveBy = stepSize;
		if (autoOn) begin
			doMove = pendSteps_ff != 9'h000;
			moveBy = autoSize;
		end else
			doMove = stepEv;
	end

	// Auto mode: each input step queues stepSize/autoSize fine steps
	always_ff @(posedge core_clk) begin
		if (rst)
			pendSteps_ff <= 9'h000;
		else if (clkEn) begin
			if (idxRst)
				pendSteps_ff <= 9'h000;
			else if (autoOn && stepEv)
				pendSteps_ff <= stepSize / autoSize;
			else if (doMove && autoOn)
				pendSteps_ff <= pendSteps_ff - 9'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Indexer: 1024-entry electrical cycle, position of coil B lags by 256
	logic [9:0] phase_ff;
	always_ff @(posedge core_clk) begin
		if (rst)
			phase_ff <= 10'h000;
		else if (clkEn) begin
			if (idxRst)
				phase_ff <= 10'h000;
			else if (doMove && driveEn)
				phase_ff <= dirPin ? phase_ff + 10'(moveBy)
					: phase_ff - 10'(moveBy);
		end
	end

	// Fold phase into 0..255..0..-255..0 triangle
	function automatic logic signed [9:0] foldPos(input logic [9:0] ph);
		logic [7:0] o;
		o = ph[7:0];
		case (ph[9:8])
			2'd0: return 10'(o);
			2'd1: return (o == 8'h00) ? sim_pkg::POS_MAX : 10'(9'h100 - o);
			2'd2: return -10'(o);
			default: return (o == 8'h00) ? -sim_pkg::POS_MAX
				: -10'(9'h100 - o);
		endcase
	endfunction

	logic signed [9:0] posA, posB;
	assign posA = foldPos(phase_ff);
	assign posB = foldPos(phase_ff - 10'h100);

	////////////////////////////////////////////////////////////////////////
	// Standstill detection and hold current
	always_ff @(posedge core_clk) begin
		if (rst)
			idleCnt_ff <= 16'h0000;
		else if (clkEn) begin
			if (stepEv)
				idleCnt_ff <= 16'h0000;
			else if (idleCnt_ff != 16'hffff)
				idleCnt_ff <= idleCnt_ff + 16'h0001;
		end
	end

	logic holding;
	// Seventeen bits so that the largest delay does not wrap to zero
	assign holding = ctrlOne_ff[sim_pkg::BIT_HOLD_EN]
		&& ({1'b0, idleCnt_ff} >= 17'h00100 + {1'b0, holdCfg_ff, 8'h00});

	function automatic logic [9:0] scaleHold(input logic [9:0] m,
			input logic [7:0] pct);
		logic [17:0] p;
		p = m * pct;
		return p[17:8];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Stall detection: learn or manual threshold, windowed compare
	logic ripple;
	assign ripple = ctrlTwo_ff[sim_pkg::FLD_DECAY_LO +: 3] == sim_pkg::DECAY_RIPPLE;

	logic stallOn, winEnd;
	assign stallOn = stallCfg_ff[sim_pkg::BIT_STALL_EN] & ripple;
	assign winEnd = winCnt_ff == 14'(sim_pkg::WINDOW_CYC - 1);

	logic [11:0] thr, cnt;
	assign cnt = stallCfg_ff[sim_pkg::BIT_X8] ? {torqueCount[8:0], 3'b000}
		: torqueCount;
	assign thr = stallCfg_ff[sim_pkg::BIT_LEARN] ? learnThr_ff
		: {stallThr_ff, 4'h0};

	always_ff @(posedge core_clk) begin
		if (rst)
			winCnt_ff <= 14'h0000;
		else if (clkEn)
			winCnt_ff <= winEnd ? 14'h0000 : winCnt_ff + 14'h0001;
	end

	// Moving means a step within the last 256 cycles, not on this very cycle
	logic moving, stallHit;
	assign moving = idleCnt_ff < 16'h0100;
	assign stallHit = stallOn && winEnd && cnt < thr && moving
		|| stallOn && winEnd && learn_ff == LRN_RUN && cnt < (learnMax_ff >> 1);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			learn_ff <= LRN_IDLE;
			learnMax_ff <= 12'h000;
			learnThr_ff <= 12'h000;
		end else if (clkEn) begin
			case (learn_ff)
				LRN_IDLE: begin
					learnMax_ff <= 12'h000;
					if (stallOn && stallCfg_ff[sim_pkg::BIT_LEARN])
						learn_ff <= LRN_RUN;
				end
				LRN_RUN: begin
					if (winEnd && cnt > learnMax_ff)
						learnMax_ff <= cnt;
					if (stallHit) begin
						learnThr_ff <= learnMax_ff >> 1;
						learn_ff <= LRN_DONE;
					end
				end
				LRN_DONE: begin
					if (!stallCfg_ff[sim_pkg::BIT_LEARN])
						learn_ff <= LRN_IDLE;
				end
				default: learn_ff <= LRN_IDLE;
			endcase
		end
	end

	logic clrFlt;
	assign clrFlt = regWr && regAddr == sim_pkg::ADDR_STALL_CFG
		&& regWdata[sim_pkg::BIT_CLR_FLT];

	always_ff @(posedge core_clk) begin
		if (rst)
			stall_flag_ff <= 1'b0;
		else if (clkEn) begin
			if (stallHit)
				stall_flag_ff <= 1'b1;
			else if (clrFlt)
				stall_flag_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register port
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrlOne_ff <= sim_pkg::RST_CTRL_ONE;
			ctrlTwo_ff <= sim_pkg::RST_CTRL_TWO;
			stallCfg_ff <= sim_pkg::RST_STALL_CFG;
			stallThr_ff <= sim_pkg::RST_STALL_THR;
			holdCfg_ff <= sim_pkg::RST_HOLD_CFG;
		end else if (clkEn) begin
			if (regWr && regAddr == sim_pkg::ADDR_CTRL_ONE)
				ctrlOne_ff <= regWdata;
			else if (idxRst)
				ctrlOne_ff[sim_pkg::BIT_INDEXER_RESET_BIT] <= 1'b0;
			if (regWr && regAddr == sim_pkg::ADDR_CTRL_TWO)
				ctrlTwo_ff <= regWdata;
			if (regWr && regAddr == sim_pkg::ADDR_STALL_CFG)
				stallCfg_ff <= {1'b0, regWdata[6:0]};
			if (regWr && regAddr == sim_pkg::ADDR_STALL_THR)
				stallThr_ff <= regWdata;
			if (regWr && regAddr == sim_pkg::ADDR_HOLD_CFG)
				holdCfg_ff <= (regWdata == 8'h00) ? 8'h03 : regWdata;
		end
	end

	for (genvar g = 0; g < sim_pkg::CUSTOM_ENTRIES; g++) begin : gCust
		always_ff @(posedge core_clk) begin
			if (rst)
				custom_ff[g] <= sim_pkg::RST_CUSTOM;
			else if (clkEn && regWr
					&& regAddr == sim_pkg::ADDR_CUSTOM_BASE + 8'(g))
				custom_ff[g] <= regWdata;
		end
	end

	logic [9:0] scalerA;
	assign scalerA = posMag(posA, ctrlOne_ff[sim_pkg::BIT_CUSTOM_EN],
		custom_ff);

	logic [7:0] rdMux;
	always_comb begin
		rdMux = 8'h00;
		case (regAddr)
			sim_pkg::ADDR_CTRL_ONE:    rdMux = ctrlOne_ff;
			sim_pkg::ADDR_CTRL_TWO:    rdMux = ctrlTwo_ff;
			sim_pkg::ADDR_STALL_CFG:   rdMux = stallCfg_ff;
			sim_pkg::ADDR_STALL_THR:   rdMux = stallThr_ff;
			sim_pkg::ADDR_HOLD_CFG:    rdMux = holdCfg_ff;
			sim_pkg::ADDR_FAULT_STAT:  rdMux = {7'h00, stall_flag_ff};
			sim_pkg::ADDR_SCALER_LOW:  rdMux = {6'h00, scalerA[1:0]};
			sim_pkg::ADDR_SCALER_HIGH: rdMux = scalerA[9:2];
			sim_pkg::ADDR_TORQUE_CNT:  rdMux = torqueCount[11:4];
			sim_pkg::ADDR_POS_A:       rdMux = posA[7:0];
			default: begin
				if (regAddr >= sim_pkg::ADDR_CUSTOM_BASE && regAddr
						< sim_pkg::ADDR_CUSTOM_BASE + 8'(sim_pkg::CUSTOM_ENTRIES))
					rdMux = custom_ff[regAddr[2:0]];
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Registered outputs
	logic [9:0] magA, magB;
	always_comb begin
		magA = scalerA;
		magB = posMag(posB, ctrlOne_ff[sim_pkg::BIT_CUSTOM_EN], custom_ff);
		if (holding) begin
			magA = scaleHold(magA, holdCfg_ff);
			magB = scaleHold(magB, holdCfg_ff);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			regRdata <= 8'h00;
			coilAMag <= 10'h000;
			coilBMag <= 10'h000;
			coilASign <= 1'b0;
			coilBSign <= 1'b0;
			driveEn <= 1'b1;
			error_out_n <= 1'b1;
		end else if (clkEn) begin
			if (regRd)
				regRdata <= rdMux;
			coilAMag <= magA;
			coilBMag <= magB;
			coilASign <= posA[9];
			coilBSign <= posB[9];
			driveEn <= ~((stall_flag_ff | stallHit)
				& ~stallCfg_ff[sim_pkg::BIT_KEEP_DRIVE]);
			error_out_n <= ~((stall_flag_ff | stallHit)
				& stallCfg_ff[sim_pkg::BIT_STALL_REP]);
		end
	end
endmodule
`default_nettype wire

// file: sim_indexer_chk.sv
// Assertions on the indexer ports: register reads, step path and faults.
// Assumes it is bound to sim_indexer and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module sim_indexer_chk (
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic       clkEn,
	input wire logic       stepPin,
	input wire logic       regWr,
	input wire logic       regRd,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic [7:0] regRdata,
	input wire logic       coilASign,
	input wire logic       driveEn,
	input wire logic       error_out_n
);
	logic [3:0] quietCnt_ff;
	logic       stepDly_ff;
	logic       wrStall;
	logic       wrIdx;
	logic       rdReq;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	assign rdReq = clkEn && regRd;
	assign wrStall = clkEn && regWr && regAddr == 8'h02;
	assign wrIdx = clkEn && regWr && regAddr == 8'h00 && regWdata[0];
	////////////////////////////////////////
	// Cycles since the last step edge or write; saturates
	always_ff @(posedge core_clk) begin
		stepDly_ff <= stepPin;
		if (rst || regWr || stepPin != stepDly_ff)
			quietCnt_ff <= 4'h0;
		else if (quietCnt_ff != 4'hf)
			quietCnt_ff <= quietCnt_ff + 4'h1;
	end
	////////////////////////////////////////
	sign_cause_a: assert property ($changed(coilASign) |-> quietCnt_ff < 4'hb)
		else $error("coil sign moved with no step edge");
	rd_hold_a: assert property (!rdReq |=> $stable(regRdata))
		else $error("read data moved without a read");
	low_bits_a: assert property (rdReq && regAddr == 8'h06
		|=> regRdata[7:2] == 6'h00) else $error("scaler low register too wide");
	unmapped_rd_a: assert property (rdReq && regAddr inside {[8'h0a:8'h0f],
		[8'h18:8'hff]} |=> regRdata == 8'h00) else $error("unmapped read not zero");
	idx_clear_a: assert property (wrIdx ##4 (rdReq && regAddr == 8'h00)
		|=> !regRdata[0]) else $error("indexer reset bit did not clear");
	pos_zero_a: assert property (wrIdx ##1 $stable(stepPin)[*5] ##1
		(rdReq && regAddr == 8'h09) |=> regRdata == 8'h00)
		else $error("position not zero after indexer reset");
	stop_latch_a: assert property (!driveEn && !wrStall && !$past(wrStall)
		|=> !driveEn)
		else $error("outputs resumed without a fault clear");
	fault_latch_a: assert property (!error_out_n && !wrStall && !$past(wrStall)
		|=> !error_out_n)
		else $error("fault pin released without a fault clear");
	cover property (!driveEn);
	cover property (!error_out_n && driveEn);
	cover property (wrIdx);
endmodule
bind sim_indexer sim_indexer_chk u_chk (.core_clk(core_clk), .rst(rst),
	.clkEn(clkEn), .stepPin(stepPin), .regWr(regWr), .regRd(regRd),
	.regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
	.coilASign(coilASign), .driveEn(driveEn), .error_out_n(error_out_n));
`default_nettype wire

// file: sim_step_ctrl.sv
// Controller model issuing step pulses on the step pin.
// Assumes go is held until busy rises; counts are even in both-edge mode.
`timescale 1ns/10ps
`default_nettype none
module sim_step_ctrl (
	input  wire logic       core_clk,
	input  wire logic       go,
	input  wire logic [7:0] steps,
	input  wire logic       bothEdge,
	output var  logic       stepPin,
	output var  logic       busy
);
	int i;
	initial begin
		stepPin = 1'b0;
		busy = 1'b0;
		forever begin
			@(negedge core_clk);
			if (go) begin
				busy = 1'b1;
				for (i = 0; i < steps; i++) begin
					// Both edges count, so one level change per step halves the rate
					stepPin = bothEdge ? ~stepPin : 1'b1;
					repeat (6) @(negedge core_clk);
					stepPin = bothEdge ? stepPin : 1'b0;
					repeat (6) @(negedge core_clk);
				end
				busy = 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the microstep indexer.
// Assumes sim_pkg, the checker and the step controller model come first.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        core_clk, rst, clkEn, dirPin, regWr, regRd, go, bothE;
	logic        stepPin, busy, coilASign, coilBSign, driveEn, error_out_n;
	logic [7:0]  regAddr, regWdata, regRdata, steps, rv, hv, cf;
	logic [7:0]  cv [8];
	logic [9:0]  coilAMag, coilBMag, sc;
	logic [11:0] torqueCount;
	int          error_cnt, checks, cyc, seed, n, k, m, c, e;
	localparam logic [7:0] R_ADR [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
		8'h10, 8'h0b};
	localparam logic [7:0] R_VAL [7] = '{sim_pkg::RST_CTRL_ONE,
		sim_pkg::RST_CTRL_TWO, sim_pkg::RST_STALL_CFG, sim_pkg::RST_STALL_THR,
		sim_pkg::RST_HOLD_CFG, sim_pkg::RST_CUSTOM, 8'h00};
	sim_indexer u_dut (.core_clk(core_clk), .rst(rst), .clkEn(clkEn),
		.stepPin(stepPin), .dirPin(dirPin), .regWr(regWr), .regRd(regRd),
		.regAddr(regAddr), .regWdata(regWdata), .torqueCount(torqueCount),
		.regRdata(regRdata), .coilAMag(coilAMag), .coilBMag(coilBMag),
		.coilASign(coilASign), .coilBSign(coilBSign), .driveEn(driveEn),
		.error_out_n(error_out_n));
	sim_step_ctrl u_ctrl (.core_clk(core_clk), .go(go), .steps(steps),
		.bothEdge(bothE), .stepPin(stepPin), .busy(busy));
	////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Reference position over 1024 microsteps: 0..255, down to -255, back to 0
	function automatic int fold(input int ph);
		int o;
		o = ph % 256;
		case (ph / 256)
			0: return o;
			1: return (o == 0) ? 255 : 256 - o;
			2: return -o;
			default: return (o == 0) ? -255 : o - 256;
		endcase
	endfunction
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		regAddr = a;
		regWdata = d;
		regWr = 1'b1;
		@(negedge core_clk);
		regWr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge core_clk);
		regAddr = a;
		regRd = 1'b1;
		@(negedge core_clk);
		regRd = 1'b0;
		rv = regRdata;
	endtask
	task automatic run(input logic [7:0] s);
		steps = s;
		go = 1'b1;
		wait (busy);
		go = 1'b0;
	endtask
	////////////////////////////////////////
	initial begin
		seed = 97;
		rst = 1'b1;
		clkEn = 1'b1;
		dirPin = 1'b1;
		regWr = 1'b0;
		regRd = 1'b0;
		go = 1'b0;
		bothE = 1'b0;
		steps = 8'h00;
		regAddr = 8'h00;
		regWdata = 8'h00;
		torqueCount = 12'hfff;
		repeat (3) @(negedge core_clk);
		rst = 1'b0;
		for (k = 0; k < 7; k++) begin
			rd(R_ADR[k]);
			chk("reset value", {2'h0, R_VAL[k]}, {2'h0, rv});
		end
		for (k = 0; k < 16; k++) begin
			if (k < 8) begin
				cv[k] = 8'($random(seed));
				wr(8'h10 + 8'(k), cv[k]);
			end else begin
				rd(8'h10 + 8'(k - 8));
				chk("custom entry", {2'h0, cv[k - 8]}, {2'h0, rv});
			end
		end
		// Modes: auto at resolution code 3 only, then rising edge, both edges, custom; four resolutions each
		for (k = 0; k < 13; k++) begin
			m = (k == 0) ? 3 : (k - 1) / 4;
			c = (k == 0) ? 3 : (k - 1) % 4;
			n = (m == 2) ? 4 : 2 + 2 * ($random(seed) & 7);
			wr(8'h01, 8'he0 | 8'(c));
			wr(8'h00, {4'h0, m == 2, m == 3, m == 1, 1'b1});
			rd(8'h0b);
			chk("unmapped read", 10'h000, {2'h0, rv});
			rd(8'h00);
			chk("control word", {6'h0, m == 2, m == 3, m == 1, 1'b0}, {2'h0, rv});
			rd(8'h09);
			chk("position after reset", 10'h000, {2'h0, rv});
			rd(8'h01);
			chk("control word two", {2'h0, 8'he0 | 8'(c)}, {2'h0, rv});
			bothE = (m == 1);
			run(8'(n));
			wait (!busy);
			rd(8'h09);
			e = fold((n * ((m == 2) ? 32 : (256 >> c))) % 1024);
			if (m != 2)
				chk("position", 10'(e & 255), {2'h0, rv});
			else
				chk("custom position", 10'(e & 255), {2'h0, rv});
		end
		rd(8'h07);
		hv = rv;
		rd(8'h06);
		sc = {hv, rv[1:0]};
		chk("scaler value", {cv[4], cv[4][7:6]}, sc);
		wr(8'h04, 8'h03);
		wr(8'h00, 8'h18);
		repeat (1100) @(negedge core_clk);
		chk("hold current", 10'((sc * 3) >> 8), coilAMag);
		rd(8'h07);
		hv = rv;
		rd(8'h06);
		chk("scaler", sc, {hv, rv[1:0]});
		// Stop on stall, keep driving, then no stall outside ripple decay
		// Then learn mode: high count while unloaded, low count stalls
		for (k = 0; k < 4; k++) begin
			cf = {3'h0, k == 1, 1'b1, k == 1, k == 3, 1'b1};
			wr(8'h01, (k == 2) ? 8'h00 : 8'he0);
			torqueCount = (k == 3) ? 12'h800 : 12'h010;
			wr(8'h03, 8'h70);
			wr(8'h02, cf);
			run(8'hc8);
			if (k == 3) begin
				repeat (1100) @(negedge core_clk);
				torqueCount = 12'h010;
			end
			for (n = 0; n < 3000 && error_out_n; n++)
				@(negedge core_clk);
			chk("fault pin", {9'h0, k == 2}, {9'h0, error_out_n});
			chk("drive enable", {9'h0, k == 1 || k == 2}, {9'h0, driveEn});
			wait (!busy);
			rd(8'h05);
			chk("stall flag", {9'h0, k != 2}, {9'h0, rv[0]});
			torqueCount = 12'hf00 | 12'($random(seed));
			wr(8'h02, cf | 8'h80);
			rd(8'h05);
			chk("stall flag cleared", 10'h000, {9'h0, rv[0]});
			chk("fault pin cleared", 10'h001, {9'h0, error_out_n});
		end
		finish_test();
	end
endmodule
`default_nettype wire
